//--- hw/tfr_params.svh
// constants for the temperature fault response block
`ifndef TFR_PARAMS_SVH
`define TFR_PARAMS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define TFR_CMD_EXT_OT_ACTION  8'h50
`define TFR_CMD_EXT_UT_ACTION  8'h54
`define TFR_CMD_INT_OT_ACTION  8'hd6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TFR_EXT_OT_RESET       8'hb8
`define TFR_EXT_UT_RESET       8'hb8
`define TFR_INT_OT_RESET       8'hc0

// ----------------------------------------------------------------------
// action byte fields
// ----------------------------------------------------------------------
`define TFR_RESP_MSB           7
`define TFR_RESP_LSB           6
`define TFR_RETRY_MSB          5
`define TFR_RETRY_LSB          3
`define TFR_DELAY_MSB          2
`define TFR_DELAY_LSB          0

`define TFR_RESP_CONTINUE      2'h0
`define TFR_RESP_UNSUP         2'h1
`define TFR_RESP_SHUTDOWN      2'h2
`define TFR_RESP_HOLD          2'h3
`define TFR_RETRY_NONE         3'h0
`define TFR_RETRY_FOREVER      3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TFR_CLK_KHZ            125000
`define TFR_UT_LAG_MS          90
`define TFR_UT_SAMPLE_CYC      (`TFR_UT_LAG_MS * `TFR_CLK_KHZ)

`endif

//--- hw/tfr_pkg.sv
// types shared by the temperature fault response block
package tfr_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD,
    ST_LATCHED,
    ST_RETRY
  } tfr_state_t;

  typedef logic [7:0] tfr_byte_t;

endpackage

//--- hw/tfr_action_reg.sv
// one action byte with reset value and guarded write
`timescale 1ns/100ps
module tfr_action_reg
  import tfr_pkg::*;
#(
  parameter tfr_byte_t RESET_VAL = 8'h00
) (
  input  wire logic      i_clk,
  input  wire logic      i_sys_rst,
  input  wire logic      i_wr,
  input  wire logic      i_ok,
  input  wire tfr_byte_t i_wdata,
  output tfr_byte_t      o_value
);

  tfr_byte_t value_reg;

  // ----------------------------------------------------------------------
  // storage, refused writes keep the old byte
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      value_reg <= RESET_VAL;
    end else if (i_wr && i_ok) begin
      value_reg <= i_wdata;
    end
  end

  assign o_value = value_reg;

endmodule

//--- hw/tfr_fault_channel.sv
// response state machine for one fault source
`timescale 1ns/100ps
`include "tfr_params.svh"
module tfr_fault_channel
  import tfr_pkg::*;
#(
  parameter int CW = 24
) (
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_fault,
  input  wire logic [1:0]    i_resp,
  input  wire logic [2:0]    i_retry,
  input  wire logic [CW-1:0] i_retry_cyc,
  input  wire logic          i_clear,
  input  wire logic          i_restart,
  output logic               o_disable
);

  tfr_state_t    state_reg;
  logic [CW-1:0] wait_reg;

  // ----------------------------------------------------------------------
  // response state
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (i_fault && i_resp == `TFR_RESP_SHUTDOWN) begin
            state_reg <= (i_retry == `TFR_RETRY_NONE) ? ST_LATCHED : ST_RETRY;
          end else if (i_fault && i_resp == `TFR_RESP_HOLD) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!i_fault) begin
            state_reg <= ST_RUN;
          end
        end
        ST_LATCHED: begin
          if (i_clear || i_restart) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RETRY: begin
          if (i_restart || wait_reg >= i_retry_cyc) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // retry interval counter
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wait_reg <= '0;
    end else if (state_reg == ST_RETRY) begin
      wait_reg <= wait_reg + CW'(1);
    end else begin
      wait_reg <= '0;
    end
  end

  assign o_disable = (state_reg != ST_RUN);

endmodule

//--- hw/tfr_top.sv
// temperature fault response logic with action bytes and status
//
// Summary of operation
// - internal overtemp sets status bits and alert
// - every response sets status and alert
// - internal response codes 00/01 raise CML
// - internal code 10 shuts down, follows retry
// - internal code 11 holds off while fault
// - internal bit clears on clear or cycle
// - internal retry 000 stays off until cleared
// - internal retry 001-111 raises CML
// - internal delay field has no effect
// - external overtemp action paged at 0x50
// - external undertemp action paged at 0x54
// - external overtemp sets temperature status bits
// - external undertemp sets temperature status bits
// - undertemp reaction may lag up to 90ms
// - external 00 continue, 10 shutdown, else CML
// - external retry 111 restarts at interval forever
// - external retry 000 stays off until cleared
// - external delay field is ignored
`timescale 1ns/100ps
`include "tfr_params.svh"
module tfr_top
  import tfr_pkg::*;
#(
  parameter int NUM_PAGES     = 2,
  parameter int PW            = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1,
  parameter int CW            = 24,
  parameter int UT_SAMPLE_CYC = `TFR_UT_SAMPLE_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_cmd_wr,
  input  wire logic                 i_cmd_rd,
  input  wire logic [7:0]           i_cmd_code,
  input  wire logic [PW-1:0]        i_cmd_page,
  input  wire tfr_byte_t            i_cmd_wdata,
  output tfr_byte_t                 o_cmd_rdata,
  output logic                      o_cmd_rvalid,
  input  wire logic                 i_clear_faults,
  input  wire logic [NUM_PAGES-1:0] i_run_cycle,
  input  wire logic [CW-1:0]        i_retry_interval_setting,
  input  wire logic                 i_int_ot,
  input  wire logic [NUM_PAGES-1:0] i_ext_ot,
  input  wire logic [NUM_PAGES-1:0] i_ext_ut,
  input  wire logic                 i_mask_int_ot,
  input  wire logic                 i_mask_ext_ot,
  input  wire logic                 i_mask_ext_ut,
  input  wire logic                 i_mask_cml,
  input  wire logic                 i_alert_i,
  output logic                      o_alert_o,
  output logic                      o_alert_oe_n,
  output logic [NUM_PAGES-1:0]      o_out_enable,
  output logic                      o_sts_none_above,
  output logic                      o_sts_word_mfr,
  output logic                      o_sts_mfr_ot,
  output logic                      o_sts_temperature,
  output logic [NUM_PAGES-1:0]      o_sts_ext_ot,
  output logic [NUM_PAGES-1:0]      o_sts_ext_ut,
  output logic                      o_cml_fault
);

  // ----------------------------------------------------------------------
  // write decode and checking
  // ----------------------------------------------------------------------
  logic [1:0] wr_resp;
  logic [2:0] wr_retry;
  logic       wr_int;
  logic       wr_ot;
  logic       wr_ut;
  logic       int_ok;
  logic       ext_ok;
  logic       bad_write;

  assign wr_resp  = i_cmd_wdata[`TFR_RESP_MSB:`TFR_RESP_LSB];
  assign wr_retry = i_cmd_wdata[`TFR_RETRY_MSB:`TFR_RETRY_LSB];
  assign wr_int   = i_cmd_wr && (i_cmd_code == `TFR_CMD_INT_OT_ACTION);
  assign wr_ot    = i_cmd_wr && (i_cmd_code == `TFR_CMD_EXT_OT_ACTION);
  assign wr_ut    = i_cmd_wr && (i_cmd_code == `TFR_CMD_EXT_UT_ACTION);

  // internal byte takes only codes 10 or 11 with retry 000
  assign int_ok = ((wr_resp == `TFR_RESP_SHUTDOWN) || (wr_resp == `TFR_RESP_HOLD))
                  && (wr_retry == `TFR_RETRY_NONE);
  // external bytes take only codes 00 or 10
  assign ext_ok = (wr_resp == `TFR_RESP_CONTINUE) || (wr_resp == `TFR_RESP_SHUTDOWN);

  assign bad_write = (wr_int && !int_ok) || ((wr_ot || wr_ut) && !ext_ok);

  // ----------------------------------------------------------------------
  // action bytes
  // ----------------------------------------------------------------------
  tfr_byte_t int_action;
  tfr_byte_t ot_action [NUM_PAGES];
  tfr_byte_t ut_action [NUM_PAGES];

  tfr_action_reg #(
    .RESET_VAL (`TFR_INT_OT_RESET)
  ) u_int_action (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (wr_int),
    .i_ok      (int_ok),
    .i_wdata   (i_cmd_wdata),
    .o_value   (int_action)
  );

  // ----------------------------------------------------------------------
  // undertemp sampling at converter rate
  // ----------------------------------------------------------------------
  logic [31:0]          ut_cnt_reg;
  logic                 ut_tick;
  logic [NUM_PAGES-1:0] ut_seen_reg;

  assign ut_tick = (ut_cnt_reg >= 32'(UT_SAMPLE_CYC - 1));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ut_cnt_reg <= 32'h0000_0000;
    end else if (ut_tick) begin
      ut_cnt_reg <= 32'h0000_0000;
    end else begin
      ut_cnt_reg <= ut_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ut_seen_reg <= '0;
    end else if (ut_tick) begin
      ut_seen_reg <= i_ext_ut;
    end
  end

  // ----------------------------------------------------------------------
  // response engines
  // ----------------------------------------------------------------------
  logic                 int_dis;
  logic [NUM_PAGES-1:0] ot_dis;
  logic [NUM_PAGES-1:0] ut_dis;
  logic                 any_cycle;

  assign any_cycle = |i_run_cycle;

  // delay field bits 2:0 are never looked at
  tfr_fault_channel #(
    .CW (CW)
  ) u_int_chan (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_fault     (i_int_ot),
    .i_resp      (int_action[`TFR_RESP_MSB:`TFR_RESP_LSB]),
    .i_retry     (int_action[`TFR_RETRY_MSB:`TFR_RETRY_LSB]),
    .i_retry_cyc (i_retry_interval_setting),
    .i_clear     (i_clear_faults),
    .i_restart   (any_cycle),
    .o_disable   (int_dis)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAGES; gp++) begin : g_page
      logic page_sel;

      assign page_sel = (i_cmd_page == PW'(gp));

      tfr_action_reg #(
        .RESET_VAL (`TFR_EXT_OT_RESET)
      ) u_ot_action (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr      (wr_ot && page_sel),
        .i_ok      (ext_ok),
        .i_wdata   (i_cmd_wdata),
        .o_value   (ot_action[gp])
      );

      tfr_action_reg #(
        .RESET_VAL (`TFR_EXT_UT_RESET)
      ) u_ut_action (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr      (wr_ut && page_sel),
        .i_ok      (ext_ok),
        .i_wdata   (i_cmd_wdata),
        .o_value   (ut_action[gp])
      );

      // delay field bits 2:0 are never looked at
      tfr_fault_channel #(
        .CW (CW)
      ) u_ot_chan (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_fault     (i_ext_ot[gp]),
        .i_resp      (ot_action[gp][`TFR_RESP_MSB:`TFR_RESP_LSB]),
        .i_retry     (ot_action[gp][`TFR_RETRY_MSB:`TFR_RETRY_LSB]),
        .i_retry_cyc (i_retry_interval_setting),
        .i_clear     (i_clear_faults),
        .i_restart   (i_run_cycle[gp]),
        .o_disable   (ot_dis[gp])
      );

      tfr_fault_channel #(
        .CW (CW)
      ) u_ut_chan (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_fault     (ut_seen_reg[gp]),
        .i_resp      (ut_action[gp][`TFR_RESP_MSB:`TFR_RESP_LSB]),
        .i_retry     (ut_action[gp][`TFR_RETRY_MSB:`TFR_RETRY_LSB]),
        .i_retry_cyc (i_retry_interval_setting),
        .i_clear     (i_clear_faults),
        .i_restart   (i_run_cycle[gp]),
        .o_disable   (ut_dis[gp])
      );

      // ------------------------------------------------------------------
      // per page status, fault present wins over clear
      // ------------------------------------------------------------------
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_sts_ext_ot[gp] <= 1'b0;
        end else if (i_ext_ot[gp]) begin
          o_sts_ext_ot[gp] <= 1'b1;
        end else if (i_clear_faults || i_run_cycle[gp]) begin
          o_sts_ext_ot[gp] <= 1'b0;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_sts_ext_ut[gp] <= 1'b0;
        end else if (ut_seen_reg[gp]) begin
          o_sts_ext_ut[gp] <= 1'b1;
        end else if (i_clear_faults || i_run_cycle[gp]) begin
          o_sts_ext_ut[gp] <= 1'b0;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_out_enable[gp] <= 1'b0;
        end else begin
          o_out_enable[gp] <= !(int_dis || ot_dis[gp] || ut_dis[gp]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // internal overtemp status
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sts_mfr_ot <= 1'b0;
    end else if (i_int_ot) begin
      o_sts_mfr_ot <= 1'b1;
    end else if (i_clear_faults || any_cycle) begin
      o_sts_mfr_ot <= 1'b0;
    end
  end

  assign o_sts_none_above  = o_sts_mfr_ot;
  assign o_sts_word_mfr    = o_sts_mfr_ot;
  assign o_sts_temperature = |{o_sts_ext_ot, o_sts_ext_ut};

  // ----------------------------------------------------------------------
  // communication fault flag
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cml_fault <= 1'b0;
    end else if (bad_write) begin
      o_cml_fault <= 1'b1;
    end else if (i_clear_faults) begin
      o_cml_fault <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // alert pin, open drain, pulled low while any unmasked fault
  // ----------------------------------------------------------------------
  logic alert_req;

  assign alert_req = (o_sts_mfr_ot && !i_mask_int_ot)
                     || (|o_sts_ext_ot && !i_mask_ext_ot)
                     || (|o_sts_ext_ut && !i_mask_ext_ut)
                     || (o_cml_fault && !i_mask_cml);

  assign o_alert_o    = 1'b0;
  assign o_alert_oe_n = !alert_req;

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  tfr_byte_t rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (i_cmd_code)
      `TFR_CMD_INT_OT_ACTION: rd_mux = int_action;
      `TFR_CMD_EXT_OT_ACTION: rd_mux = ot_action[i_cmd_page];
      `TFR_CMD_EXT_UT_ACTION: rd_mux = ut_action[i_cmd_page];
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cmd_rdata  <= 8'h00;
      o_cmd_rvalid <= 1'b0;
    end else begin
      o_cmd_rvalid <= i_cmd_rd;
      if (i_cmd_rd) begin
        o_cmd_rdata <= rd_mux;
      end
    end
  end

endmodule

//--- verification/tfr_top_asserts.sv
// checker on the temperature fault response top ports
`timescale 1ns/100ps
`include "tfr_params.svh"
module tfr_top_asserts
  import tfr_pkg::*;
#(
  parameter int NP  = 2,
  parameter int UTC = 4
) (
  input wire logic          i_clk,
  input wire logic          i_sys_rst,
  input wire logic          i_cmd_wr,
  input wire logic          i_cmd_rd,
  input wire logic [7:0]    i_cmd_code,
  input wire tfr_byte_t     i_cmd_wdata,
  input wire logic          o_cmd_rvalid,
  input wire logic          i_clear_faults,
  input wire logic [NP-1:0] i_run_cycle,
  input wire logic          i_int_ot,
  input wire logic [NP-1:0] i_ext_ot,
  input wire logic [NP-1:0] i_ext_ut,
  input wire logic          i_mask_int_ot,
  input wire logic          o_alert_oe_n,
  input wire logic [NP-1:0] o_out_enable,
  input wire logic          o_sts_none_above,
  input wire logic          o_sts_word_mfr,
  input wire logic          o_sts_mfr_ot,
  input wire logic          o_sts_temperature,
  input wire logic [NP-1:0] o_sts_ext_ot,
  input wire logic [NP-1:0] o_sts_ext_ut,
  input wire logic          o_cml_fault
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ----
  // undertemp run length
  // ----
  int ut_run_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_ext_ut[0]) begin
      ut_run_reg <= 0;
    end else begin
      ut_run_reg <= ut_run_reg + 1;
    end
  end
  sequence int_trip_s;
    i_int_ot;
  endsequence
  sequence all_off_s;
    o_out_enable == '0;
  endsequence
  sequence read_s;
    i_cmd_rd ##1 !i_cmd_rd;
  endsequence
  // ----
  // assertions
  // ----
  int_status_a: assert property (int_trip_s |=> o_sts_mfr_ot)
    else $error("internal status not set");
  status_mirror_a: assert property (o_sts_none_above == o_sts_mfr_ot && o_sts_word_mfr == o_sts_mfr_ot)
    else $error("status mirrors differ");
  int_alert_a: assert property (o_sts_mfr_ot && !i_mask_int_ot && $stable(i_mask_int_ot) |-> !o_alert_oe_n)
    else $error("alert not driven");
  alert_cause_a: assert property (!o_alert_oe_n |-> o_sts_mfr_ot || o_sts_temperature || o_cml_fault)
    else $error("alert without cause");
  int_bad_code_a: assert property (i_cmd_wr && i_cmd_code == `TFR_CMD_INT_OT_ACTION
    && (!i_cmd_wdata[7] || i_cmd_wdata[5:3] != 3'h0) |-> ##[1:2] o_cml_fault) else $error("no cml fault");
  int_shutdown_a: assert property (int_trip_s |-> ##2 all_off_s)
    else $error("output not disabled");
  int_latch_a: assert property (o_sts_mfr_ot && !i_clear_faults && i_run_cycle == '0 |=> o_sts_mfr_ot)
    else $error("status dropped");
  int_clear_a: assert property ((i_clear_faults || i_run_cycle != '0) && !i_int_ot |=> !o_sts_mfr_ot)
    else $error("status not cleared");
  ext_ot_a: assert property (i_ext_ot[0] |=> o_sts_ext_ot[0] && o_sts_temperature)
    else $error("ext overtemp status not set");
  ut_lag_a: assert property (ut_run_reg >= UTC + 2 |-> o_sts_ext_ut[0])
    else $error("undertemp status late");
  temp_sum_a: assert property (o_sts_temperature == (o_sts_ext_ot != '0 || o_sts_ext_ut != '0))
    else $error("temperature summary wrong");
  read_answer_a: assert property (read_s |-> o_cmd_rvalid ##1 !o_cmd_rvalid)
    else $error("read answer wrong");
endmodule
bind tfr_top tfr_top_asserts #(.NP(NUM_PAGES), .UTC(UT_SAMPLE_CYC)) tfr_top_asserts_inst (.*);

//--- verification/tfr_host_model.sv
// host model driving the command byte bus
`timescale 1ns/100ps
module tfr_host_model
  import tfr_pkg::*;
#(
  parameter int PW = 1
) (
  input  wire logic      i_clk,
  output logic           o_cmd_wr,
  output logic           o_cmd_rd,
  output logic [7:0]     o_cmd_code,
  output logic [PW-1:0]  o_cmd_page,
  output tfr_byte_t      o_cmd_wdata,
  input  wire tfr_byte_t i_cmd_rdata,
  input  wire logic      i_cmd_rvalid
);
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_page = '0;
    o_cmd_wdata = 8'h00;
  end
  // one request held to its edge, then idle lines invert
  task automatic put(input logic w, input logic [7:0] c, input logic [PW-1:0] p, input tfr_byte_t d);
    @(posedge i_clk);
    o_cmd_wr <= w;
    o_cmd_rd <= !w;
    o_cmd_code <= c;
    o_cmd_page <= p;
    o_cmd_wdata <= d;
    @(posedge i_clk);
    o_cmd_wr <= 1'b0;
    o_cmd_rd <= 1'b0;
    o_cmd_code <= ~c;
    o_cmd_page <= ~p;
    o_cmd_wdata <= ~d;
  endtask
  task automatic write_byte(input logic [7:0] c, input logic [PW-1:0] p, input tfr_byte_t d);
    put(1'b1, c, p, d);
  endtask
  task automatic read_byte(input logic [7:0] c, input logic [PW-1:0] p, output tfr_byte_t d, output logic ok);
    put(1'b0, c, p, 8'h00);
    #1;
    ok = i_cmd_rvalid;
    d = i_cmd_rdata;
  endtask
endmodule

//--- verification/tfr_top_tb.sv
// self-checking bench for the temperature fault response block
`timescale 1ns/100ps
`include "tfr_params.svh"
module tfr_top_tb
  import tfr_pkg::*;
;
  localparam int NP = 2;
  logic            clk, rst, wr, rd, rvalid, clr, int_ot, mask_int, mfr, none_ab, word_mfr, temp, cml, oe_n, ok;
  logic            mask_ot, mask_ut, mask_cml, alert_o;
  logic [23:0]     retry_cyc;
  logic [7:0]      code;
  logic [0:0]      page, p;
  tfr_byte_t       wdata, rdata, b;
  logic [NP-1:0]   run_cyc, ext_ot, ext_ut, out_en, sts_ot, sts_ut;
  int              fail_count, checks_done, k;
  integer          seed;
  tfr_byte_t       exp_val [3][NP];
  logic [7:0]      codes [3] = '{`TFR_CMD_EXT_OT_ACTION, `TFR_CMD_EXT_UT_ACTION, `TFR_CMD_INT_OT_ACTION};
  int              ck [6] = '{0, 1, 2, 2, 2, 2};
  tfr_byte_t       cb [6] = '{8'h40, 8'hc7, 8'h00, 8'h48, 8'hb8, 8'h87};
  tfr_top #(.NUM_PAGES(NP), .CW(24), .UT_SAMPLE_CYC(4)) tfr_top_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_cmd_wr(wr), .i_cmd_rd(rd), .i_cmd_code(code), .i_cmd_page(page),
    .i_cmd_wdata(wdata), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid), .i_clear_faults(clr),
    .i_run_cycle(run_cyc), .i_retry_interval_setting(retry_cyc), .i_int_ot(int_ot), .i_ext_ot(ext_ot),
    .i_ext_ut(ext_ut), .i_mask_int_ot(mask_int), .i_mask_ext_ot(mask_ot), .i_mask_ext_ut(mask_ut),
    .i_mask_cml(mask_cml), .i_alert_i(oe_n), .o_alert_o(alert_o), .o_alert_oe_n(oe_n), .o_out_enable(out_en),
    .o_sts_none_above(none_ab), .o_sts_word_mfr(word_mfr), .o_sts_mfr_ot(mfr), .o_sts_temperature(temp),
    .o_sts_ext_ot(sts_ot), .o_sts_ext_ut(sts_ut), .o_cml_fault(cml));
  tfr_host_model #(.PW(1)) tfr_host_model_inst (.i_clk(clk), .o_cmd_wr(wr), .o_cmd_rd(rd), .o_cmd_code(code),
    .o_cmd_page(page), .o_cmd_wdata(wdata), .i_cmd_rdata(rdata), .i_cmd_rvalid(rvalid));
  // ----
  // helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic legal(input logic [7:0] c, input tfr_byte_t v);
    if (c == `TFR_CMD_INT_OT_ACTION) begin
      return v[7] && v[5:3] == 3'h0;
    end
    return !v[6];
  endfunction
  task automatic check_byte(input string what, input tfr_byte_t e, input tfr_byte_t g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic c, input logic [NP-1:0] r);
    @(posedge clk);
    clr <= c;
    run_cyc <= r;
    @(posedge clk);
    clr <= 1'b0;
    run_cyc <= '0;
    settle(3);
  endtask
  task automatic read_cmp(input int i, input logic [0:0] pg);
    tfr_byte_t d;
    logic v;
    tfr_host_model_inst.read_byte(codes[i], pg, d, v);
    check_byte("read valid", 8'h01, {7'h0, v});
    check_byte("read data", exp_val[i][pg], d);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 400 cycles the tests need
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  // ----
  // tests
  // ----
  initial begin
    seed = 32'h6f26_90d9;
    {fail_count, checks_done} = '0;
    {rst, clr, int_ot, mask_int, mask_ot, mask_ut, mask_cml} = 7'h40;
    retry_cyc = 24'h00_000a;
    {run_cyc, ext_ot, ext_ut} = '0;
    exp_val = '{'{8'hb8, 8'hb8}, '{8'hb8, 8'hb8}, '{8'hc0, 8'hc0}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      read_cmp(i % 3, 1'(i / 3));
    end
    $display("test reset values done");
    for (int i = 0; i < 30; i++) begin
      k = (i < 6) ? ck[i] : int'($unsigned($random(seed)) % 3);
      p = 1'($random(seed));
      b = (i < 6) ? cb[i] : 8'($random(seed));
      tfr_host_model_inst.write_byte(codes[k], p, b);
      ok = legal(codes[k], b);
      if (ok) begin
        exp_val[k][p] = b;
        exp_val[k][~p] = (k == 2) ? b : exp_val[k][~p];
      end
      settle(1);
      check_byte("cml fault", {7'h0, !ok}, {7'h0, cml});
      check_byte("cml alert", {7'h0, ok}, {7'h0, oe_n});
      read_cmp(k, p);
      if (!ok) begin
        pulse(1'b1, '0);
      end
    end
    $display("test byte access done");
    tfr_host_model_inst.write_byte(codes[2], 1'b0, 8'hc0 | 8'($random(seed) & 7));
    @(posedge clk);
    {mask_int, int_ot} <= 2'b11;
    settle(3);
    check_byte("status", 8'h0f, {3'h0, alert_o, mfr, none_ab, word_mfr, oe_n});
    check_byte("output enable", 8'h00, {6'h0, out_en});
    @(posedge clk);
    {mask_int, int_ot} <= 2'b00;
    settle(4);
    check_byte("status alert", 8'h02, {6'h0, mfr, oe_n});
    check_byte("output enable", 8'h03, {6'h0, out_en});
    pulse(1'b1, '0);
    check_byte("status alert", 8'h01, {6'h0, mfr, oe_n});
    $display("test internal hold done");
    tfr_host_model_inst.write_byte(codes[2], 1'b0, 8'h80 | 8'($random(seed) & 7));
    @(posedge clk);
    int_ot <= 1'b1;
    @(posedge clk);
    int_ot <= 1'b0;
    settle(20);
    check_byte("output enable", 8'h00, {6'h0, out_en});
    pulse(1'b0, 2'b10);
    check_byte("enable status", 8'h06, {5'h0, out_en, mfr});
    $display("test internal latch done");
    tfr_host_model_inst.write_byte(codes[0], 1'b0, 8'hb8 ^ 8'($random(seed) & 7));
    @(posedge clk);
    ext_ot <= 2'b01;
    settle(3);
    check_byte("ext trip", 8'h0e, {3'h0, sts_ot, temp, out_en});
    @(posedge clk);
    ext_ot <= '0;
    settle(4);
    check_byte("output enable", 8'h02, {6'h0, out_en});
    settle(14);
    check_byte("ext retried", 8'h0f, {3'h0, sts_ot, temp, out_en});
    pulse(1'b1, '0);
    tfr_host_model_inst.write_byte(codes[0], 1'b1, {2'b00, 6'($random(seed))});
    @(posedge clk);
    ext_ot <= 2'b10;
    settle(3);
    check_byte("ext continue", 8'h17, {2'h0, oe_n, sts_ot, temp, out_en});
    @(posedge clk);
    mask_ot <= 1'b1;
    settle(1);
    check_byte("ot mask", 8'h01, {7'h0, oe_n});
    @(posedge clk);
    ext_ot <= '0;
    mask_ot <= 1'b0;
    pulse(1'b1, '0);
    check_byte("temperature", 8'h00, {7'h0, temp});
    $display("test external overtemp done");
    tfr_host_model_inst.write_byte(codes[1], 1'b0, 8'h80 | 8'($random(seed) & 7));
    @(posedge clk);
    ext_ut <= 2'b01;
    settle(10);
    check_byte("ut trip", 8'h0e, {2'h0, oe_n, sts_ut, temp, out_en});
    @(posedge clk);
    mask_ut <= 1'b1;
    settle(1);
    check_byte("ut mask", 8'h01, {7'h0, oe_n});
    @(posedge clk);
    ext_ut <= '0;
    mask_ut <= 1'b0;
    settle(20);
    check_byte("output enable", 8'h02, {6'h0, out_en});
    pulse(1'b0, 2'b01);
    check_byte("ut cleared", 8'h03, {3'h0, sts_ut, temp, out_en});
    $display("test external undertemp done");
    stop_test();
  end
endmodule
